// ---- include/rbc_params.svh ----
// Offsets, field positions, reset values and timing counts of the reset and boot option block.
`ifndef RBC_PARAMS_SVH
`define RBC_PARAMS_SVH
`define RBC_FLAGS_OFS 8'h86
`define RBC_SUPPLY_OFS 8'h8e
`define RBC_POR_BIT 7
`define RBC_WDT_BIT 6
`define RBC_RST_BIT 5
`define RBC_STACK_OVERFLOW_FLAG_BIT 4
`define RBC_MID_BIT 6
`define RBC_HIGH_BIT 5
`define RBC_ALU_MSB 2
`define RBC_DEBOUNCE_TICKS 8'h80
`define RBC_WARM_RC 12'h010
`define RBC_WARM_XTAL 12'h800
`define RBC_WDT_BITS 8
`define RBC_PC_RESET 14'h0000
`endif

// ---- include/rbc_pkg.sv ----
// Types of the reset and boot option block.
package rbc_pkg;
   typedef enum logic [1:0] {RBC_HCLK_RC = 2'h0, RBC_HCLK_X16 = 2'h1, RBC_HCLK_X12 = 2'h2}
      rbc_hclk_t;
   typedef enum logic [1:0] {RBC_WDT_OFF = 2'h0, RBC_WDT_ON = 2'h1, RBC_WDT_ALWAYS = 2'h2}
      rbc_wdt_mode_t;
   typedef enum logic [1:0] {RBC_LVL_L = 2'h0, RBC_LVL_M = 2'h1, RBC_LVL_H = 2'h2,
      RBC_LVL_MAX = 2'h3} rbc_lvl_t;
   typedef enum logic [2:0] {RBC_ST_HOLD = 3'h0, RBC_ST_PIN = 3'h1, RBC_ST_INIT = 3'h3,
      RBC_ST_WARM = 3'h2, RBC_ST_RUN = 3'h6} rbc_state_t;
   typedef struct packed {
      rbc_hclk_t hclk;
      logic [1:0] fcpu_div;
      logic [1:0] low_fcpu_div;
      logic [1:0] watchdog_clock_select;
      rbc_wdt_mode_t wdt_mode;
      logic pin_is_reset;
      logic debounce;
      logic secure;
      rbc_lvl_t lvl;
      logic noise_filter;
   } rbc_opt_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } rbc_bus_t;
   typedef struct packed {
      logic supply_ok;
      logic mid_low;
      logic high_low;
   } rbc_supply_t;
endpackage

// ---- hdl/rbc_top.sv ----
// Reset sequencer with boot option decoding, cause flags and clock dividers.
//
// Behaviour
// - Fast clock: internal RC, 16 MHz or 12 MHz crystal.
// - Normal instruction clock is fast clock /1,/2,/4,/8.
// - Slow instruction clock is slow RC /1,/2,/4,/8.
// - Watchdog clock is slow RC /4,/8,/16,/32.
// - Always-on watchdog counts also when sleeping.
// - Enabled watchdog stops and clears to zero asleep; disabled never resets.
// - Reset pin option: falling edge resets system.
// - Port option: pin is GPIO, no external reset.
// - Optional debounce of 128 slow RC periods.
// - Protection option blocks full program memory readout.
// - Detector level picks flags and reset sources.
// - Noise filter option, forced on by crystal.
// - Any reset stops core, clears counter to zero.
// - Power or low-voltage reset sets flag bit 7.
// - Watchdog overflow reset sets flag bit 6.
// - External pin reset sets flag bit 5.
// - Power-up: supply, pin high, init, warm, run.
// - Watchdog reset: init, warm up, resume normal mode.
// - Stack overflow flag cleared only by reset.
// - Low-voltage reset clears mid and high flags.
// - At level M, mid flag reads one while supply is low.
//
// Decided for this implementation: the address-and-strobe port.
`include "rbc_params.svh"
module rbc_top #(
   parameter logic [11:0] WARM_RC = `RBC_WARM_RC,
   parameter logic [11:0] WARM_XTAL = `RBC_WARM_XTAL,
   parameter int WDT_BITS = `RBC_WDT_BITS
) (
   input wire logic I_CLK,
   input wire logic I_NRST,
   input wire logic I_CE,
   input wire rbc_pkg::rbc_opt_t I_OPT,
   input wire logic I_FAST_TICK,
   input wire logic I_SLOW_TICK,
   input wire logic I_SLOW_MODE,
   input wire logic I_SLEEP,
   input wire logic I_WDT_CLEAR,
   input wire rbc_pkg::rbc_supply_t I_SUPPLY,
   input wire logic I_STACK_OVF,
   input wire logic I_RST_PIN_I,
   input wire logic I_GPIO_O,
   input wire logic I_GPIO_OE,
   input wire rbc_pkg::rbc_bus_t I_BUS,
   output logic [7:0] O_RDATA,
   output logic O_CORE_RST_N,
   output logic [13:0] O_PC_INIT,
   output logic O_CPU_TICK,
   output logic O_WDT_TICK,
   output logic O_RST_PIN_O,
   output logic O_RST_PIN_OE,
   output logic O_GPIO_I,
   output logic O_XIN_GPIO_EN,
   output logic O_XTAL_EN,
   output logic O_XTAL_12M,
   output logic O_NOISE_FILTER,
   output logic O_READ_BLOCK
);
   import rbc_pkg::*;

   typedef struct packed {
      rbc_state_t st;
      rbc_opt_t opt;
      logic por;
      logic wdt;
      logic rst;
      logic stack_overflow_flag;
      logic [2:0] alu;
      logic mid;
      logic high;
      logic pin_low_q;
      logic [7:0] db_cnt;
      logic [2:0] cpu_div;
      logic [4:0] wdt_div;
      logic [WDT_BITS-1:0] wdt_cnt;
      logic [11:0] warm_cnt;
      logic [7:0] rdata;
      logic core_rst_n;
      logic cpu_tick;
      logic wdt_tick;
      logic pin_o;
      logic pin_oe;
      logic gpio_i;
      logic xin_gpio;
      logic xtal_en;
      logic xtal_12m;
      logic nf;
      logic rd_block;
   } rbc_regs_t;

   rbc_regs_t s_reg;
   rbc_regs_t s_next;

   logic lv_rst;
   logic pin_act;
   logic pin_evt;
   logic wdt_evt;
   logic cpu_src;
   logic [2:0] cpu_mask;
   logic [4:0] wdt_mask;
   logic wdt_run;
   logic [11:0] warm_len;

   // Decode which supply detectors reset the chip at the chosen level.
   always_comb
   begin
      lv_rst = ~I_SUPPLY.supply_ok;
      if (s_reg.opt.lvl == RBC_LVL_H || s_reg.opt.lvl == RBC_LVL_MAX)
      begin
         lv_rst = lv_rst | I_SUPPLY.mid_low;
      end
      if (s_reg.opt.lvl == RBC_LVL_MAX)
      begin
         lv_rst = lv_rst | I_SUPPLY.high_low;
      end
   end

   // Pin qualification: raw low level, or low held for the debounce time.
   always_comb
   begin
      if (s_reg.opt.debounce)
      begin
         pin_act = (s_reg.db_cnt == `RBC_DEBOUNCE_TICKS);
      end
      else
      begin
         pin_act = ~I_RST_PIN_I;
      end
      pin_act = pin_act & s_reg.opt.pin_is_reset;
      pin_evt = pin_act & ~s_reg.pin_low_q;
   end

   // Divider selection for the instruction and watchdog clocks.
   always_comb
   begin
      cpu_src = I_SLOW_MODE ? I_SLOW_TICK : I_FAST_TICK;
      if (I_SLOW_MODE)
      begin
         cpu_mask = 3'((4'h1 << s_reg.opt.low_fcpu_div) - 4'h1);
      end
      else
      begin
         cpu_mask = 3'((4'h1 << s_reg.opt.fcpu_div) - 4'h1);
      end
      wdt_mask = 5'((6'h4 << s_reg.opt.watchdog_clock_select) - 6'h1);
      case (s_reg.opt.wdt_mode)
         RBC_WDT_ALWAYS: wdt_run = 1'b1;
         RBC_WDT_ON: wdt_run = ~I_SLEEP;
         default: wdt_run = 1'b0;
      endcase
      wdt_evt = wdt_run && s_reg.st == RBC_ST_RUN && s_reg.wdt_tick && ~I_WDT_CLEAR
         && (&s_reg.wdt_cnt);
      warm_len = (s_reg.opt.hclk == RBC_HCLK_RC) ? WARM_RC : WARM_XTAL;
   end

   // Next state of the whole block.
   always_comb
   begin
      s_next = s_reg;
      s_next.cpu_tick = 1'b0;
      s_next.wdt_tick = 1'b0;

      // Instruction clock divider runs on the selected source tick.
      if (cpu_src)
      begin
         s_next.cpu_div = s_reg.cpu_div + 3'h1;
         s_next.cpu_tick = ((s_reg.cpu_div & cpu_mask) == cpu_mask);
      end

      // Watchdog clock divider on slow RC ticks.
      if (I_SLOW_TICK)
      begin
         s_next.wdt_div = s_reg.wdt_div + 5'h1;
         s_next.wdt_tick = ((s_reg.wdt_div & wdt_mask) == wdt_mask);
      end

      // Watchdog counter; software clear from the main loop restarts it.
      if (s_reg.st != RBC_ST_RUN || I_WDT_CLEAR || !wdt_run)
      begin
         s_next.wdt_cnt = '0;
      end
      else if (s_reg.wdt_tick)
      begin
         s_next.wdt_cnt = s_reg.wdt_cnt + WDT_BITS'(1);
      end

      // Debounce counter counts slow RC periods while the pin stays low.
      if (I_RST_PIN_I)
      begin
         s_next.db_cnt = 8'h00;
      end
      else if (I_SLOW_TICK && s_reg.db_cnt != `RBC_DEBOUNCE_TICKS)
      begin
         s_next.db_cnt = s_reg.db_cnt + 8'h01;
      end
      s_next.pin_low_q = pin_act;

      // Supply flags follow the detectors only at the level that enables them.
      s_next.mid = (s_reg.opt.lvl == RBC_LVL_M) & I_SUPPLY.mid_low;
      s_next.high = (s_reg.opt.lvl == RBC_LVL_H) & I_SUPPLY.high_low;

      // Stack overflow is set by the core and never cleared by software.
      if (I_STACK_OVF)
      begin
         s_next.stack_overflow_flag = 1'b1;
      end

      // Register writes reach only the arithmetic flag bits.
      if (I_BUS.we && I_BUS.addr == `RBC_FLAGS_OFS && s_reg.core_rst_n)
      begin
         s_next.alu = I_BUS.wdata[`RBC_ALU_MSB:0];
      end

      // Read data stands in the cycle after the read strobe only.
      s_next.rdata = 8'h00;
      if (I_BUS.re && I_BUS.addr == `RBC_FLAGS_OFS)
      begin
         s_next.rdata[`RBC_POR_BIT] = s_reg.por;
         s_next.rdata[`RBC_WDT_BIT] = s_reg.wdt;
         s_next.rdata[`RBC_RST_BIT] = s_reg.rst;
         s_next.rdata[`RBC_STACK_OVERFLOW_FLAG_BIT] = s_reg.stack_overflow_flag;
         s_next.rdata[`RBC_ALU_MSB:0] = s_reg.alu;
      end
      else if (I_BUS.re && I_BUS.addr == `RBC_SUPPLY_OFS)
      begin
         s_next.rdata[`RBC_MID_BIT] = s_reg.mid;
         s_next.rdata[`RBC_HIGH_BIT] = s_reg.high;
      end

      // Reset sequencer.
      case (s_reg.st)
         RBC_ST_HOLD:
         begin
            s_next.opt = I_OPT; // Options are caught while the chip is held.
            if (!lv_rst)
            begin
               s_next.st = RBC_ST_PIN;
            end
         end
         RBC_ST_PIN:
         begin
            if (!s_reg.opt.pin_is_reset || I_RST_PIN_I)
            begin
               s_next.st = RBC_ST_INIT;
            end
         end
         RBC_ST_INIT:
         begin
            s_next.warm_cnt = 12'h000;
            s_next.alu = 3'h0;
            s_next.st = RBC_ST_WARM;
         end
         RBC_ST_WARM:
         begin
            if (s_reg.warm_cnt != warm_len)
            begin
               s_next.warm_cnt = s_reg.warm_cnt + 12'(I_FAST_TICK);
            end
            else if (s_next.cpu_tick)
            begin
               s_next.core_rst_n = 1'b1;
               s_next.st = RBC_ST_RUN;
            end
         end
         RBC_ST_RUN:
         begin
            s_next.core_rst_n = 1'b1;
         end
         default:
         begin
            s_next.st = RBC_ST_HOLD;
         end
      endcase

      // Reset events: supply first, then the pin, then the watchdog.
      if (lv_rst && s_reg.st != RBC_ST_HOLD)
      begin
         s_next.st = RBC_ST_HOLD;
         s_next.core_rst_n = 1'b0;
         {s_next.por, s_next.wdt, s_next.rst} = 3'h4;
         s_next.stack_overflow_flag = 1'b0;
         s_next.mid = 1'b0;
         s_next.high = 1'b0;
      end
      else if (pin_evt && s_reg.st != RBC_ST_HOLD)
      begin
         s_next.st = RBC_ST_PIN;
         s_next.core_rst_n = 1'b0;
         {s_next.por, s_next.wdt, s_next.rst} = 3'h1;
         s_next.stack_overflow_flag = 1'b0;
      end
      else if (wdt_evt)
      begin
         s_next.st = RBC_ST_INIT;
         s_next.core_rst_n = 1'b0;
         {s_next.por, s_next.wdt, s_next.rst} = 3'h2;
         s_next.stack_overflow_flag = 1'b0;
      end

      // Option decoding driven to the clock, pad and memory logic.
      s_next.xin_gpio = (s_reg.opt.hclk == RBC_HCLK_RC);
      s_next.xtal_en = (s_reg.opt.hclk != RBC_HCLK_RC);
      s_next.xtal_12m = (s_reg.opt.hclk == RBC_HCLK_X12);
      s_next.nf = s_reg.opt.noise_filter | (s_reg.opt.hclk != RBC_HCLK_RC);
      s_next.rd_block = s_reg.opt.secure;
      s_next.pin_o = I_GPIO_O;
      s_next.pin_oe = I_GPIO_OE & ~s_reg.opt.pin_is_reset & s_reg.core_rst_n;
      s_next.gpio_i = I_RST_PIN_I & ~s_reg.opt.pin_is_reset;
   end

   // State register; the clock enable freezes everything.
   always_ff @(posedge I_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         s_reg <= '0;
         s_reg.st <= RBC_ST_HOLD;
         s_reg.por <= 1'b1;
         s_reg.rd_block <= 1'b1;
      end
      else if (I_CE)
      begin
         s_reg <= s_next;
      end
   end

   // Outputs other than the fixed restart address come straight from the state register.
   assign O_RDATA = s_reg.rdata;
   assign O_CORE_RST_N = s_reg.core_rst_n;
   assign O_PC_INIT = `RBC_PC_RESET;
   assign O_CPU_TICK = s_reg.cpu_tick;
   assign O_WDT_TICK = s_reg.wdt_tick;
   assign O_RST_PIN_O = s_reg.pin_o;
   assign O_RST_PIN_OE = s_reg.pin_oe;
   assign O_GPIO_I = s_reg.gpio_i;
   assign O_XIN_GPIO_EN = s_reg.xin_gpio;
   assign O_XTAL_EN = s_reg.xtal_en;
   assign O_XTAL_12M = s_reg.xtal_12m;
   assign O_NOISE_FILTER = s_reg.nf;
   assign O_READ_BLOCK = s_reg.rd_block;
endmodule

// ---- testbench/rbc_assertions.sv ----
// Port checker of the reset and boot option block.
`include "rbc_params.svh"
module rbc_assertions
(
   input wire logic I_CLK,
   input wire logic I_NRST,
   input wire logic I_CE,
   input wire rbc_pkg::rbc_supply_t I_SUPPLY,
   input wire rbc_pkg::rbc_bus_t I_BUS,
   input wire logic [7:0] O_RDATA,
   input wire logic O_CORE_RST_N,
   input wire logic [13:0] O_PC_INIT,
   input wire logic O_CPU_TICK,
   input wire logic O_XIN_GPIO_EN,
   input wire logic O_XTAL_EN,
   input wire logic O_XTAL_12M,
   input wire logic O_NOISE_FILTER
);
   timeunit 1ns;
   timeprecision 100ps;
   import rbc_pkg::*;
   // All checks share the one clock and its reset.
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_NRST);
   a_pc_zero: assert property (O_PC_INIT == `RBC_PC_RESET)
      else $error("restart address not zero");
   a_filter_forced: assert property (O_XTAL_EN |-> O_NOISE_FILTER)
      else $error("crystal without noise filter");
   a_xtal_kinds: assert property (O_XTAL_12M |-> O_XTAL_EN && !O_XIN_GPIO_EN)
      else $error("fast clock decode wrong");
   a_release_tick: assert property ($rose(O_CORE_RST_N) |-> O_CPU_TICK)
      else $error("core released off a tick");
   a_boot_hold: assert property ($rose(I_NRST) |-> !O_CORE_RST_N [*4])
      else $error("core released too early");
   a_lv_reset: assert property (I_CE && !I_SUPPLY.supply_ok |=> !O_CORE_RST_N)
      else $error("low supply did not reset");
   a_rdata_idle: assert property (!$past(I_BUS.re) |-> O_RDATA == 8'h00)
      else $error("read data outside its cycle");
   a_flag_shape: assert property ($past(I_BUS.re) && $past(I_BUS.addr) == `RBC_FLAGS_OFS
      |-> $onehot0(O_RDATA[7:5]) && !O_RDATA[3])
      else $error("cause flags not exclusive");
endmodule
bind rbc_top rbc_assertions chk_u (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_CE(I_CE),
   .I_SUPPLY(I_SUPPLY), .I_BUS(I_BUS), .O_RDATA(O_RDATA), .O_CORE_RST_N(O_CORE_RST_N),
   .O_PC_INIT(O_PC_INIT), .O_CPU_TICK(O_CPU_TICK), .O_XIN_GPIO_EN(O_XIN_GPIO_EN),
   .O_XTAL_EN(O_XTAL_EN), .O_XTAL_12M(O_XTAL_12M), .O_NOISE_FILTER(O_NOISE_FILTER));

// ---- testbench/rbc_partner.sv ----
// Far-side model: reset pin with pull-up and the two oscillators.
module rbc_partner
(
   input wire logic i_clk,
   input wire logic i_pin_low,
   input wire logic i_pin_oe,
   input wire logic i_pin_o,
   output logic o_pin,
   output logic o_fast,
   output logic o_slow
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] cnt_reg = 3'h0;
   // The pin idles high through its pull-up unless the device drives it as a port.
   assign o_pin = i_pin_oe ? i_pin_o : !i_pin_low;
   // Fast ticks come every second cycle, slow ticks every eighth.
   always_ff @(posedge i_clk)
   begin
      cnt_reg <= cnt_reg + 3'h1;
   end
   assign o_fast = cnt_reg[0];
   assign o_slow = (cnt_reg == 3'h7);
endmodule

// ---- testbench/reset_and_boot_option_control_tb_top.sv ----
// Self-checking bench of the reset and boot option block.
module reset_and_boot_option_control_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import rbc_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, slow_mode = 1'b0, sleep = 1'b0, stk = 1'b0, pin_low = 1'b0;
   rbc_opt_t opt = '0;
   rbc_supply_t sup = 3'h4;
   rbc_bus_t bus = '0;
   logic [7:0] rdata;
   logic gpio_o = 1'b0, gpio_oe = 1'b0, wdt_clr = 1'b0;
   logic core_n, cpu_t, wdt_t, pin_o, pin_oe, pin, fast, slow, gpio_i, xin, xtal, x12, nf, blk;
   int errors = 0, samples_checked = 0, cycles = 0;
   always #2.5 clk = !clk;
   rbc_top #(.WARM_RC(12'h004), .WARM_XTAL(12'h004), .WDT_BITS(8)) dut_u (
      .I_CLK(clk), .I_NRST(nrst), .I_CE(1'b1), .I_OPT(opt), .I_FAST_TICK(fast),
      .I_SLOW_TICK(slow), .I_SLOW_MODE(slow_mode), .I_SLEEP(sleep), .I_WDT_CLEAR(wdt_clr),
      .I_SUPPLY(sup), .I_STACK_OVF(stk), .I_RST_PIN_I(pin), .I_GPIO_O(gpio_o),
      .I_GPIO_OE(gpio_oe),
      .I_BUS(bus), .O_RDATA(rdata), .O_CORE_RST_N(core_n), .O_PC_INIT(), .O_CPU_TICK(cpu_t),
      .O_WDT_TICK(wdt_t), .O_RST_PIN_O(pin_o), .O_RST_PIN_OE(pin_oe), .O_GPIO_I(gpio_i),
      .O_XIN_GPIO_EN(xin), .O_XTAL_EN(xtal), .O_XTAL_12M(x12), .O_NOISE_FILTER(nf),
      .O_READ_BLOCK(blk));
   rbc_partner partner_u (.i_clk(clk), .i_pin_low(pin_low), .i_pin_oe(pin_oe),
      .i_pin_o(pin_o), .o_pin(pin), .o_fast(fast), .o_slow(slow));
   // Comparison, verdict and bus access helpers.
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic close_out();
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) bus <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus <= '0;
      #1 chk("rdata", exp, rdata);
   endtask
   task automatic wait_core(input logic lvl);
      int n = 0;
      while (core_n !== lvl && n < 10000)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk("core", 8'(lvl), 8'(core_n));
   endtask
   task automatic boot(input rbc_opt_t o);
      @(posedge clk) opt <= o;
      nrst <= 1'b0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      wait_core(1'b1);
   endtask
   task automatic count(output int c, output int w);
      c = 0;
      w = 0;
      repeat (256)
      begin
         @(posedge clk);
         #1 c += int'(cpu_t);
         w += int'(wdt_t);
      end
   endtask
   // Main sequence of scenarios.
   initial
   begin
      int c, w;
      rbc_opt_t o;
      o = '0;
      boot(o);
      rd(8'h86, 8'h80);
      wr(8'h86, 8'hff);
      rd(8'h86, 8'h87);
      rd(8'h87, 8'h00);
      @(posedge clk) stk <= 1'b1;
      @(posedge clk) stk <= 1'b0;
      wr(8'h86, 8'h00);
      rd(8'h86, 8'h90);
      // In port use the core drives the pin and reads it back.
      @(posedge clk) gpio_oe <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("pin_oe", 8'h01, 8'(pin_oe));
      chk("gpio_in", 8'h00, 8'(gpio_i));
      @(posedge clk) gpio_o <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("pin_out", 8'h01, 8'(pin_o));
      chk("gpio_in", 8'h01, 8'(gpio_i));
      @(posedge clk) gpio_oe <= 1'b0;
      gpio_o <= 1'b0;
      @(posedge clk) pin_low <= 1'b1;
      repeat (300) @(posedge clk);
      #1 chk("gpio", 8'h00, 8'(gpio_i));
      chk("core", 8'h01, 8'(core_n));
      @(posedge clk) pin_low <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         o.hclk = rbc_hclk_t'(2'(i % 3));
         o.fcpu_div = 2'(i);
         o.low_fcpu_div = 2'(i);
         o.watchdog_clock_select = 2'(i);
         o.wdt_mode = RBC_WDT_ON;
         o.secure = i[0];
         o.noise_filter = i[1];
         boot(o);
         chk("xtal", 8'(i % 3 != 0), 8'(xtal));
         chk("x12", 8'(i % 3 == 2), 8'(x12));
         chk("xin", 8'(i % 3 == 0), 8'(xin));
         chk("nf", 8'(i % 3 != 0 || i[1]), 8'(nf));
         chk("blk", 8'(i[0]), 8'(blk));
         count(c, w);
         chk("cpu", 8'(128 >> i), 8'(c));
         chk("wdt", 8'(8 >> i), 8'(w));
         @(posedge clk) slow_mode <= 1'b1;
         repeat (64) @(posedge clk);
         count(c, w);
         chk("slow", 8'(32 >> i), 8'(c));
         @(posedge clk) slow_mode <= 1'b0;
      end
      o.watchdog_clock_select = 2'h0;
      o.pin_is_reset = 1'b1;
      o.debounce = 1'b1;
      o.lvl = RBC_LVL_M;
      boot(o);
      @(posedge clk) sleep <= 1'b1;
      repeat (9000) @(posedge clk);
      #1 chk("sleep", 8'h01, 8'(core_n));
      @(posedge clk) sleep <= 1'b0;
      // Clearing the watchdog from one place in time keeps the core running.
      repeat (12)
      begin
         repeat (900) @(posedge clk);
         wdt_clr <= 1'b1;
         @(posedge clk) wdt_clr <= 1'b0;
      end
      #1 chk("clear", 8'h01, 8'(core_n));
      wait_core(1'b0);
      wait_core(1'b1);
      rd(8'h86, 8'h40);
      o.wdt_mode = RBC_WDT_ALWAYS;
      boot(o);
      @(posedge clk) sleep <= 1'b1;
      wait_core(1'b0);
      @(posedge clk) sleep <= 1'b0;
      wait_core(1'b1);
      rd(8'h86, 8'h40);
      @(posedge clk) sup <= 3'h6;
      rd(8'h8e, 8'h40);
      // In reset-pin use the core's port drive must never reach the pin.
      @(posedge clk) gpio_oe <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("pin_oe", 8'h00, 8'(pin_oe));
      chk("gpio_in", 8'h00, 8'(gpio_i));
      @(posedge clk) gpio_oe <= 1'b0;
      @(posedge clk) pin_low <= 1'b1;
      repeat (900) @(posedge clk);
      #1 chk("bounce", 8'h01, 8'(core_n));
      wait_core(1'b0);
      repeat (50) @(posedge clk);
      #1 chk("pin_hold", 8'h00, 8'(core_n));
      @(posedge clk) pin_low <= 1'b0;
      wait_core(1'b1);
      rd(8'h86, 8'h20);
      @(posedge clk) sup <= 3'h2;
      wait_core(1'b0);
      @(posedge clk) sup <= 3'h4;
      wait_core(1'b1);
      rd(8'h86, 8'h80);
      rd(8'h8e, 8'h00);
      close_out();
   end
   // Hang guard.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 60000)
      begin
         errors++;
         close_out();
      end
   end
endmodule
